// ### bkpt_pkg.sv
// Overview of operation
// - Eight trigger slots, shared debug and machine
// - Index picks slot; words one/two access it
// - Control top nibble reads kind 2, or 0 on a debug-claimed slot outside debug mode
// - Action holds only exception or debug entry
// - Load, store, fetch enables in any combination
// - Machine, supervisor, user enables in any combination
// - Match kinds: exact, power-of-two, chained range
// - Trailing ones plus zero give range size
// - Capability field reads largest range log, 4
// - Largest encoding ignores only the low four address bits
// - Chain on lower slot gates higher slot
// - Range pair compares greater-equal then less-than
// - Timing and select bits always read zero
// - Machine access to debug-only slot is illegal
// - Traps precise; debug or breakpoint exception path
// - Debug-claimed slot reads kind 0 from machine
`default_nettype none
package bkpt_pkg;
   localparam int num_slots = 8;
   localparam int slot_idx_w = 3;
   localparam int bit_load = 0;
   localparam int bit_store = 1;
   localparam int bit_fetch = 2;
   localparam int bit_user = 3;
   localparam int bit_super = 4;
   localparam int bit_mach = 6;
   localparam int match_lo = 7;
   localparam int match_hi = 10;
   localparam int bit_chain = 11;
   localparam int action_lo = 12;
   localparam int action_hi = 17;
   localparam int bit_timing = 18;
   localparam int bit_select = 19;
   localparam int maskmax_lo = 21;
   localparam int maskmax_hi = 26;
   localparam int bit_dmode = 27;
   localparam int kind_lo = 28;
   localparam int kind_hi = 31;
   localparam logic [3:0] kind_addr_match = 4'h2;
   localparam logic [3:0] kind_none = 4'h0;
   localparam logic [5:0] maskmax_val = 6'h04;
   localparam logic [3:0] match_exact = 4'h0;
   localparam logic [3:0] match_napot = 4'h1;
   localparam logic [3:0] match_ge = 4'h2;
   localparam logic [3:0] match_lt = 4'h3;
   localparam logic [5:0] action_exc = 6'h00;
   localparam logic [5:0] action_debug = 6'h01;
   localparam logic [31:0] ctrl_rst = 32'h0000_0000;
   localparam logic [31:0] addr_rst = 32'h0000_0000;
   localparam logic [2:0] index_rst = 3'h0;
   localparam logic [1:0] sel_index = 2'h0;
   localparam logic [1:0] sel_word_one = 2'h1;
   localparam logic [1:0] sel_word_two = 2'h2;
   localparam logic [1:0] sel_word_three = 2'h3;
   localparam logic [1:0] priv_user = 2'h0;
   localparam logic [1:0] priv_super = 2'h1;
   localparam logic [1:0] priv_mach = 2'h3;
endpackage
`default_nettype wire

// ### bkpt_slot_match.sv
`default_nettype none
module bkpt_slot_match (
   input wire logic [31:0] ctrl,
   input wire logic [31:0] match_addr,
   input wire logic [31:0] access_addr,
   input wire logic is_load,
   input wire logic is_store,
   input wire logic is_fetch,
   input wire logic [1:0] priv,
   output logic hit
);
   logic kind_ok;
   logic priv_ok;
   logic addr_ok;
   logic [31:0] ignore_mask;
   logic [3:0] mkind;

   always_comb begin
      mkind = ctrl[bkpt_pkg::match_hi:bkpt_pkg::match_lo];
      kind_ok = (is_load && ctrl[bkpt_pkg::bit_load])
         || (is_store && ctrl[bkpt_pkg::bit_store])
         || (is_fetch && ctrl[bkpt_pkg::bit_fetch]);
      priv_ok = (priv == bkpt_pkg::priv_mach && ctrl[bkpt_pkg::bit_mach])
         || (priv == bkpt_pkg::priv_super && ctrl[bkpt_pkg::bit_super])
         || (priv == bkpt_pkg::priv_user && ctrl[bkpt_pkg::bit_user]);
      // Ranges are capped at 16 bytes, the advertised capability
      if (!match_addr[0]) begin
         ignore_mask = 32'h0000_0001;
      end else if (!match_addr[1]) begin
         ignore_mask = 32'h0000_0003;
      end else if (!match_addr[2]) begin
         ignore_mask = 32'h0000_0007;
      end else begin
         ignore_mask = 32'h0000_000f;
      end
      if (mkind == bkpt_pkg::match_napot) begin
         addr_ok = ((access_addr ^ match_addr) & ~ignore_mask) == 32'h0000_0000;
      end else if (mkind == bkpt_pkg::match_ge) begin
         addr_ok = access_addr >= match_addr;
      end else if (mkind == bkpt_pkg::match_lt) begin
         addr_ok = access_addr < match_addr;
      end else begin
         addr_ok = access_addr == match_addr;
      end
      hit = kind_ok && priv_ok && addr_ok;
   end
endmodule
`default_nettype wire

// ### hw_breakpoint_triggers.sv
`default_nettype none
module hw_breakpoint_triggers (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic debug_mode,
   input wire logic csr_req,
   input wire logic [1:0] csr_sel,
   input wire logic csr_we,
   input wire logic [31:0] csr_wdata,
   output logic [31:0] csr_rdata,
   output logic csr_ack,
   output logic csr_illegal,
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_pc,
   input wire logic mem_valid,
   input wire logic mem_store,
   input wire logic [31:0] mem_addr,
   input wire logic [1:0] priv,
   output logic trap_exc,
   output logic trap_debug,
   output logic [31:0] trap_tval,
   output logic [2:0] trap_slot
);
   localparam int n = bkpt_pkg::num_slots;

   logic [31:0] ctrl_r [n];
   logic [31:0] ctrl_nxt [n];
   logic [31:0] addr_r [n];
   logic [31:0] addr_nxt [n];
   logic [2:0] index_r;
   logic [2:0] index_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic ack_r;
   logic ack_nxt;
   logic illegal_r;
   logic illegal_nxt;
   logic exc_r;
   logic exc_nxt;
   logic dbg_r;
   logic dbg_nxt;
   logic [31:0] tval_r;
   logic [31:0] tval_nxt;
   logic [2:0] slot_r;
   logic [2:0] slot_nxt;

   logic [n-1:0] fetch_raw;
   logic [n-1:0] mem_raw;
   logic [n-1:0] fetch_fire;
   logic [n-1:0] mem_fire;

   // Stored form of a written control word with every field legalised
   function automatic logic [31:0] legal_ctrl(input logic [31:0] w, input logic [31:0] old,
                                              input logic dbg, input logic last);
      logic [31:0] c;
      logic [3:0] mk;
      logic [5:0] act;
      c = 32'h0000_0000;
      mk = w[bkpt_pkg::match_hi:bkpt_pkg::match_lo];
      act = w[bkpt_pkg::action_hi:bkpt_pkg::action_lo];
      c[bkpt_pkg::bit_load] = w[bkpt_pkg::bit_load];
      c[bkpt_pkg::bit_store] = w[bkpt_pkg::bit_store];
      c[bkpt_pkg::bit_fetch] = w[bkpt_pkg::bit_fetch];
      c[bkpt_pkg::bit_user] = w[bkpt_pkg::bit_user];
      c[bkpt_pkg::bit_super] = w[bkpt_pkg::bit_super];
      c[bkpt_pkg::bit_mach] = w[bkpt_pkg::bit_mach];
      if (mk == bkpt_pkg::match_exact || mk == bkpt_pkg::match_napot
          || mk == bkpt_pkg::match_ge || mk == bkpt_pkg::match_lt) begin
         c[bkpt_pkg::match_hi:bkpt_pkg::match_lo] = mk;
      end else begin
         c[bkpt_pkg::match_hi:bkpt_pkg::match_lo] =
            old[bkpt_pkg::match_hi:bkpt_pkg::match_lo];
      end
      // Highest slot has no partner above it
      c[bkpt_pkg::bit_chain] = w[bkpt_pkg::bit_chain] && !last;
      if (act == bkpt_pkg::action_exc || act == bkpt_pkg::action_debug) begin
         c[bkpt_pkg::action_hi:bkpt_pkg::action_lo] = act;
      end else begin
         c[bkpt_pkg::action_hi:bkpt_pkg::action_lo] =
            old[bkpt_pkg::action_hi:bkpt_pkg::action_lo];
      end
      // Only debug mode may claim or release a slot
      if (dbg) begin
         c[bkpt_pkg::bit_dmode] = w[bkpt_pkg::bit_dmode];
      end else begin
         c[bkpt_pkg::bit_dmode] = old[bkpt_pkg::bit_dmode];
      end
      return c;
   endfunction

   // Read-back view with constant fields inserted
   function automatic logic [31:0] view_ctrl(input logic [31:0] c, input logic dbg);
      logic [31:0] v;
      v = c;
      v[bkpt_pkg::bit_timing] = 1'b0;
      v[bkpt_pkg::bit_select] = 1'b0;
      v[bkpt_pkg::maskmax_hi:bkpt_pkg::maskmax_lo] = bkpt_pkg::maskmax_val;
      if (c[bkpt_pkg::bit_dmode] && !dbg) begin
         v[bkpt_pkg::kind_hi:bkpt_pkg::kind_lo] = bkpt_pkg::kind_none;
      end else begin
         v[bkpt_pkg::kind_hi:bkpt_pkg::kind_lo] = bkpt_pkg::kind_addr_match;
      end
      return v;
   endfunction

   genvar g;
   generate
      for (g = 0; g < n; g++) begin : slot
         bkpt_slot_match fetch_cmp (
            .ctrl(ctrl_r[g]),
            .match_addr(addr_r[g]),
            .access_addr(fetch_pc),
            .is_load(1'b0),
            .is_store(1'b0),
            .is_fetch(fetch_valid),
            .priv(priv),
            .hit(fetch_raw[g])
         );
         bkpt_slot_match mem_cmp (
            .ctrl(ctrl_r[g]),
            .match_addr(addr_r[g]),
            .access_addr(mem_addr),
            .is_load(mem_valid && !mem_store),
            .is_store(mem_valid && mem_store),
            .is_fetch(1'b0),
            .priv(priv),
            .hit(mem_raw[g])
         );
      end
   endgenerate

   // Per-slot fields that the match and access paths look at
   logic [n-1:0] chain_on;
   logic [n-1:0] act_dbg;
   logic [n-1:0] claimed;
   logic [n-1:0] fire_sel;
   logic mem_won;
   logic fire_any;

   always_comb begin
      for (int i = 0; i < n; i++) begin
         chain_on[i] = ctrl_r[i][bkpt_pkg::bit_chain];
         act_dbg[i] = ctrl_r[i][bkpt_pkg::action_hi:bkpt_pkg::action_lo]
            == bkpt_pkg::action_debug;
         claimed[i] = ctrl_r[i][bkpt_pkg::bit_dmode];
      end
   end

   // Chain gating: a chained lower slot never acts alone
   always_comb begin
      for (int i = 0; i < n; i++) begin
         fetch_fire[i] = fetch_raw[i] && !chain_on[i];
         mem_fire[i] = mem_raw[i] && !chain_on[i];
         if (i > 0) begin
            if (chain_on[i-1]) begin
               fetch_fire[i] = fetch_fire[i] && fetch_raw[i-1];
               mem_fire[i] = mem_fire[i] && mem_raw[i-1];
            end
         end
      end
   end

   // Memory access is the older instruction, so its hits win
   always_comb begin
      mem_won = |mem_fire;
      if (mem_won) begin
         fire_sel = mem_fire;
      end else begin
         fire_sel = fetch_fire;
      end
      // No triggers fire while the hart is already in debug mode
      fire_any = |fire_sel && !debug_mode;
   end

   // Trap report; cause address and slot hold until the next trap
   always_comb begin
      logic found;
      found = 1'b0;
      dbg_nxt = 1'b0;
      tval_nxt = tval_r;
      slot_nxt = slot_r;
      if (fire_any) begin
         if (mem_won) begin
            tval_nxt = mem_addr;
         end else begin
            tval_nxt = fetch_pc;
         end
         for (int i = 0; i < n; i++) begin
            if (fire_sel[i] && !found) begin
               found = 1'b1;
               slot_nxt = 3'(i);
            end
            if (fire_sel[i] && act_dbg[i]) begin
               dbg_nxt = 1'b1;
            end
         end
      end
      exc_nxt = fire_any && !dbg_nxt;
   end

   // Indirect register access through the selection index
   logic blocked;
   logic wr_index;
   logic wr_ctrl;
   logic wr_addr;

   always_comb begin
      blocked = claimed[index_r] && !debug_mode;
      wr_index = csr_req && csr_we && csr_sel == bkpt_pkg::sel_index
         && csr_wdata < 32'(n);
      wr_ctrl = csr_req && csr_we && csr_sel == bkpt_pkg::sel_word_one && !blocked;
      wr_addr = csr_req && csr_we && csr_sel == bkpt_pkg::sel_word_two && !blocked;
   end

   // Slot storage: one word of the selected slot changes per write
   always_comb begin
      index_nxt = index_r;
      for (int i = 0; i < n; i++) begin
         ctrl_nxt[i] = ctrl_r[i];
         addr_nxt[i] = addr_r[i];
      end
      if (wr_index) begin
         index_nxt = csr_wdata[2:0];
      end
      if (wr_ctrl) begin
         ctrl_nxt[index_r] = legal_ctrl(csr_wdata, ctrl_r[index_r], debug_mode,
                                        index_r == 3'(n - 1));
      end
      if (wr_addr) begin
         addr_nxt[index_r] = csr_wdata;
      end
   end

   // Read response: old contents, or zero when refused
   always_comb begin
      ack_nxt = csr_req;
      illegal_nxt = 1'b0;
      rdata_nxt = rdata_r;
      if (csr_req) begin
         if (csr_sel == bkpt_pkg::sel_index) begin
            rdata_nxt = {29'h0000_0000, index_r};
         end else if (blocked) begin
            illegal_nxt = 1'b1;
            rdata_nxt = 32'h0000_0000;
         end else if (csr_sel == bkpt_pkg::sel_word_one) begin
            rdata_nxt = view_ctrl(ctrl_r[index_r], debug_mode);
         end else if (csr_sel == bkpt_pkg::sel_word_two) begin
            rdata_nxt = addr_r[index_r];
         end else begin
            rdata_nxt = 32'h0000_0000;
         end
      end
   end

   // Slot storage and selection index
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < n; i++) begin
            ctrl_r[i] <= bkpt_pkg::ctrl_rst;
            addr_r[i] <= bkpt_pkg::addr_rst;
         end
         index_r <= bkpt_pkg::index_rst;
      end else begin
         for (int i = 0; i < n; i++) begin
            ctrl_r[i] <= ctrl_nxt[i];
            addr_r[i] <= addr_nxt[i];
         end
         index_r <= index_nxt;
      end
   end

   // Access response, one cycle after the request
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= 32'h0000_0000;
         ack_r <= 1'b0;
         illegal_r <= 1'b0;
      end else begin
         rdata_r <= rdata_nxt;
         ack_r <= ack_nxt;
         illegal_r <= illegal_nxt;
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         exc_r <= 1'b0;
         dbg_r <= 1'b0;
         tval_r <= 32'h0000_0000;
         slot_r <= 3'h0;
      end else begin
         exc_r <= exc_nxt;
         dbg_r <= dbg_nxt;
         tval_r <= tval_nxt;
         slot_r <= slot_nxt;
      end
   end

   assign csr_rdata = rdata_r;
   assign csr_ack = ack_r;
   assign csr_illegal = illegal_r;
   assign trap_exc = exc_r;
   assign trap_debug = dbg_r;
   assign trap_tval = tval_r;
   assign trap_slot = slot_r;
endmodule
`default_nettype wire

// ### hw_breakpoint_triggers_props.sv
`default_nettype none
module trig_chk (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic debug_mode,
   input wire logic csr_req,
   input wire logic [1:0] csr_sel,
   input wire logic [31:0] csr_rdata,
   input wire logic csr_ack,
   input wire logic csr_illegal,
   input wire logic fetch_valid,
   input wire logic [31:0] fetch_pc,
   input wire logic mem_valid,
   input wire logic trap_exc,
   input wire logic trap_debug,
   input wire logic [31:0] trap_tval
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   sequence word_one_dbg;
      csr_req && debug_mode && csr_sel == 2'h1;
   endsequence
   ack_follows_req_a: assert property (csr_req |=> csr_ack) else $error("ack missing");
   ack_only_req_a: assert property (!csr_req |=> !csr_ack) else $error("stray ack");
   kind_field_a: assert property (word_one_dbg |=> csr_rdata[31:28] == 4'h2)
      else $error("kind field wrong");
   range_cap_a: assert property (word_one_dbg |=> csr_rdata[26:21] == 6'h04)
      else $error("range capability wrong");
   timing_select_a: assert property (word_one_dbg |=> csr_rdata[19:18] == 2'h0)
      else $error("timing or select set");
   word_three_a: assert property (csr_req && csr_sel == 2'h3 |=> csr_rdata == 32'h0)
      else $error("word three not zero");
   illegal_blank_a: assert property (csr_illegal |-> csr_ack && csr_rdata == 32'h0)
      else $error("refused access leaks data");
   dbg_legal_a: assert property (csr_req && debug_mode |=> !csr_illegal)
      else $error("debug access refused");
   idle_quiet_a: assert property (!fetch_valid && !mem_valid |=> !trap_exc && !trap_debug)
      else $error("trap without access");
   one_action_a: assert property (!(trap_exc && trap_debug)) else $error("two actions");
   fetch_tval_a: assert property ((trap_exc || trap_debug) && !$past(mem_valid)
      |-> trap_tval == $past(fetch_pc)) else $error("fetch address not recorded");
   cover property (trap_exc);
   cover property (trap_debug);
   cover property (csr_illegal);
endmodule
bind hw_breakpoint_triggers trig_chk chk (.clock(clock), .arst_n(arst_n),
   .debug_mode(debug_mode), .csr_req(csr_req), .csr_sel(csr_sel), .csr_rdata(csr_rdata),
   .csr_ack(csr_ack), .csr_illegal(csr_illegal), .fetch_valid(fetch_valid),
   .fetch_pc(fetch_pc), .mem_valid(mem_valid), .trap_exc(trap_exc), .trap_debug(trap_debug),
   .trap_tval(trap_tval));
`default_nettype wire

// ### hart_pipe_model.sv
`default_nettype none
module hart_pipe_model (
   input wire logic clock,
   output logic fetch_valid,
   output logic [31:0] fetch_pc,
   output logic mem_valid,
   output logic mem_store,
   output logic [31:0] mem_addr,
   output logic [1:0] priv
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      fetch_valid = 1'b0;
      mem_valid = 1'b0;
      mem_store = 1'b0;
      fetch_pc = 32'h0;
      mem_addr = 32'h0;
      priv = 2'h3;
   end
   // Kind 0 load, 1 store, 2 fetch; one access cycle
   task automatic access(input logic [1:0] k, input logic [31:0] a, input logic [1:0] p);
      @(negedge clock);
      priv = p;
      fetch_valid = (k == 2'h2);
      mem_valid = (k != 2'h2);
      mem_store = (k == 2'h1);
      fetch_pc = (k == 2'h2) ? a : ~a;
      mem_addr = (k == 2'h2) ? ~a : a;
      @(negedge clock);
      fetch_valid = 1'b0;
      mem_valid = 1'b0;
      fetch_pc = ~fetch_pc;
      mem_addr = ~mem_addr;
   endtask
endmodule
`default_nettype wire

// ### test_hw_breakpoint_triggers.sv
`default_nettype none
module test_hw_breakpoint_triggers;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, arst_n, debug_mode, csr_req, csr_we, csr_ack, csr_illegal, il;
   logic fetch_valid, mem_valid, mem_store, trap_exc, trap_debug;
   logic [1:0] csr_sel, priv;
   logic [2:0] trap_slot;
   logic [31:0] csr_wdata, csr_rdata, fetch_pc, mem_addr, trap_tval, rd;
   int fail_count = 0;
   int tests_run = 0;
   hw_breakpoint_triggers DUT (.clock(clock), .arst_n(arst_n), .debug_mode(debug_mode),
      .csr_req(csr_req), .csr_sel(csr_sel), .csr_we(csr_we), .csr_wdata(csr_wdata),
      .csr_rdata(csr_rdata), .csr_ack(csr_ack), .csr_illegal(csr_illegal),
      .fetch_valid(fetch_valid), .fetch_pc(fetch_pc), .mem_valid(mem_valid),
      .mem_store(mem_store), .mem_addr(mem_addr), .priv(priv), .trap_exc(trap_exc),
      .trap_debug(trap_debug), .trap_tval(trap_tval), .trap_slot(trap_slot));
   hart_pipe_model hart (.clock(clock), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
      .mem_valid(mem_valid), .mem_store(mem_store), .mem_addr(mem_addr), .priv(priv));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic csr(input logic [1:0] s, input logic w, input logic [31:0] d);
      @(negedge clock);
      csr_req = 1'b1;
      csr_sel = s;
      csr_we = w;
      csr_wdata = d;
      @(negedge clock);
      csr_req = 1'b0;
      rd = csr_rdata;
      il = csr_illegal;
      chk({31'h0, csr_ack}, 32'h1);
   endtask
   task automatic slot(input logic [31:0] i, input logic [31:0] c, input logic [31:0] a);
      csr(2'h0, 1'b1, i);
      csr(2'h2, 1'b1, a);
      csr(2'h1, 1'b1, c);
   endtask
   // Expect {debug, exception} pulse after one access
   task automatic hit(input logic [1:0] k, input logic [31:0] a, input logic [1:0] p,
                      input logic [1:0] e);
      hart.access(k, a, p);
      chk({30'h0, trap_debug, trap_exc}, {30'h0, e});
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      $display("watchdog expired");
      report_and_stop();
   end
   initial begin
      arst_n = 1'b0;
      debug_mode = 1'b0;
      csr_req = 1'b0;
      csr_sel = 2'h0;
      csr_we = 1'b0;
      csr_wdata = 32'h0;
      repeat (20) @(posedge clock);
      @(negedge clock);
      arst_n = 1'b1;
      csr(2'h1, 1'b0, 32'h0);
      chk(rd, 32'h2080_0000);
      csr(2'h1, 1'b1, 32'hffff_ffff);
      csr(2'h1, 1'b0, 32'h0);
      chk(rd, 32'h2080_085f);
      csr(2'h1, 1'b1, 32'h0000_1180);
      csr(2'h1, 1'b1, 32'h0000_2200);
      csr(2'h1, 1'b0, 32'h0);
      chk(rd, 32'h2080_1180);
      for (int i = 0; i < 8; i++) slot(32'(i), 32'h0, 32'h4000_0000 + 32'(i));
      csr(2'h0, 1'b1, 32'h8);
      csr(2'h0, 1'b0, 32'h0);
      chk(rd, 32'h7);
      for (int i = 0; i < 8; i++) begin
         csr(2'h0, 1'b1, 32'(i));
         csr(2'h2, 1'b0, 32'h0);
         chk(rd, 32'h4000_0000 + 32'(i));
      end
      csr(2'h3, 1'b1, 32'hffff_ffff);
      csr(2'h3, 1'b0, 32'h0);
      chk(rd, 32'h0);
      $display("test registers done");
      for (int e = 0; e < 8; e++) begin
         slot(32'h0, 32'h40 | 32'(e), 32'h4000_0000);
         for (int k = 0; k < 3; k++) hit(2'(k), 32'h4000_0000, 2'h3, {1'b0, e[k]});
      end
      for (int e = 0; e < 8; e++) begin
         slot(32'h0, {25'h0, e[2], 1'b0, e[1], e[0], 3'h4}, 32'h4000_0000);
         hit(2'h2, 32'h4000_0000, 2'h0, {1'b0, e[0]});
         hit(2'h2, 32'h4000_0000, 2'h1, {1'b0, e[1]});
         hit(2'h2, 32'h4000_0000, 2'h3, {1'b0, e[2]});
      end
      chk(trap_tval, 32'h4000_0000);
      chk({29'h0, trap_slot}, 32'h0);
      hit(2'h2, 32'h4000_0001, 2'h3, 2'h0);
      $display("test qualifiers done");
      slot(32'h1, 32'h0000_00c1, 32'h1000_0003);
      hit(2'h0, 32'h1000_0000, 2'h3, 2'h1);
      hit(2'h0, 32'h1000_0007, 2'h3, 2'h1);
      chk({29'h0, trap_slot}, 32'h1);
      hit(2'h0, 32'h1000_0008, 2'h3, 2'h0);
      csr(2'h2, 1'b1, 32'h1000_000f);
      hit(2'h0, 32'h1000_000f, 2'h3, 2'h1);
      hit(2'h0, 32'h1000_0010, 2'h3, 2'h0);
      slot(32'h2, 32'h0000_0941, 32'h2000_0010);
      slot(32'h3, 32'h0000_11c1, 32'h2000_0020);
      hit(2'h0, 32'h2000_000f, 2'h3, 2'h0);
      hit(2'h0, 32'h2000_0010, 2'h3, 2'h2);
      hit(2'h0, 32'h2000_001f, 2'h3, 2'h2);
      chk(trap_tval, 32'h2000_001f);
      hit(2'h0, 32'h2000_0020, 2'h3, 2'h0);
      $display("test matching done");
      @(negedge clock);
      debug_mode = 1'b1;
      slot(32'h4, 32'h0800_0044, 32'h4000_0004);
      csr(2'h1, 1'b0, 32'h0);
      chk(rd, 32'h2880_0044);
      @(negedge clock);
      debug_mode = 1'b0;
      csr(2'h1, 1'b0, 32'h0);
      chk({il, rd[30:0]}, 32'h8000_0000);
      csr(2'h2, 1'b1, 32'h0000_1234);
      chk({31'h0, il}, 32'h1);
      @(negedge clock);
      debug_mode = 1'b1;
      csr(2'h2, 1'b0, 32'h0);
      chk(rd, 32'h4000_0004);
      hit(2'h2, 32'h4000_0004, 2'h3, 2'h0);
      @(negedge clock);
      debug_mode = 1'b0;
      hit(2'h2, 32'h4000_0004, 2'h3, 2'h1);
      chk({29'h0, trap_slot}, 32'h4);
      chk(trap_tval, 32'h4000_0004);
      $display("test debug ownership done");
      report_and_stop();
   end
endmodule
`default_nettype wire
